/* verilog/flash_seq_params.svh */
// Constants for the self-programming flash sequencer and its core-side end.
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ----------------------------------------------------------------
// Array organisation
// ----------------------------------------------------------------
`define ADDR_W          24
`define WORD_W          24
`define ROW_INSTR       64
`define SLOT_W          6
`define LAST_SLOT       6'h3F
`define PAGE_ROWS       8
`define PAGE_INSTR      512
`define ROW_BYTES       192
`define PAGE_BYTES      1536
`define ROW_ADDR_MASK   24'hFFFF80
`define PAGE_ADDR_MASK  24'hFFFC00

// ----------------------------------------------------------------
// Control register and unlock key
// ----------------------------------------------------------------
`define CTRL_WR_BIT     15
`define CTRL_WREN_BIT   14
`define CTRL_ERR_BIT    13
`define OP_WORD         4'h1
`define OP_ROW          4'h2
`define OP_ERASE        4'h3
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define PROG_SETTLE_NS  160
`define ERASE_TIME_NS   320

`endif

/* verilog/flash_seq_pkg.sv */
// Types shared by the flash sequencer and its core-side end.
package flash_seq_pkg;

   typedef enum logic [1:0] {st_idle, st_load, st_settle, st_erase} seq_state_t;

   typedef enum logic [1:0] {key_none, key_first, key_done} key_state_t;

   typedef enum logic [1:0] {cmd_load_low, cmd_load_high, cmd_start} cmd_kind_t;

   typedef enum logic [2:0] {h_idle, h_tw, h_key1, h_key2, h_ctrl, h_wait} host_state_t;

endpackage

/* verilog/flash_seq_if.sv */
// Connection between the processor core end and the flash sequencer.
`timescale 1ns/1ps
interface flash_seq_if;
   logic        tw_valid;
   logic        tw_high;
   logic [23:0] tw_addr;
   logic [15:0] tw_data;
   logic        tw_ack;
   logic        key_write;
   logic [7:0]  key_data;
   logic        ctrl_write;
   logic [15:0] ctrl_wdata;
   logic [15:0] ctrl_rdata;
   logic        stall;

   modport dev
   (
      input  tw_valid,
      input  tw_high,
      input  tw_addr,
      input  tw_data,
      output tw_ack,
      input  key_write,
      input  key_data,
      input  ctrl_write,
      input  ctrl_wdata,
      output ctrl_rdata,
      output stall
   );

   modport core
   (
      output tw_valid,
      output tw_high,
      output tw_addr,
      output tw_data,
      input  tw_ack,
      output key_write,
      output key_data,
      output ctrl_write,
      output ctrl_wdata,
      input  ctrl_rdata,
      input  stall
   );
endinterface

/* verilog/flash_sequencer_device.sv */
// Flash self-programming sequencer: holding buffer, unlock, program and erase.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_sequencer_device
   import flash_seq_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                reset,
   flash_seq_if.dev                 core,
   output logic                     array_we,
   output logic [`ADDR_W-1:0]       array_addr,
   output logic [`WORD_W-1:0]       array_data,
   output logic                     array_erase,
   output logic                     busy
);

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int  PROG_CYC_I  = (`PROG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int  ERASE_CYC_I = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam logic [7:0] PROG_CYC  = 8'(PROG_CYC_I);
   localparam logic [7:0] ERASE_CYC = 8'(ERASE_CYC_I);

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [`WORD_W-1:0]  buffer [0:`ROW_INSTR-1];
   logic                tw_phase;
   logic [`ADDR_W-1:0]  target;
   key_state_t          key_state;
   logic                wr;
   logic                wren;
   logic                err;
   logic [3:0]          op;
   seq_state_t          state;
   logic [`SLOT_W-1:0]  slot;
   logic [7:0]          wait_cnt;
   logic [3:0]          start_op;
   logic                op_valid;
   logic                start_req;
   logic                start_ok;
   logic                done;
   logic [`SLOT_W-1:0]  tw_slot;

   // ----------------------------------------------------------------
   // Start qualification
   // ----------------------------------------------------------------
   assign start_op  = core.ctrl_wdata[3:0];
   assign op_valid  = (start_op == `OP_WORD) || (start_op == `OP_ROW) || (start_op == `OP_ERASE);
   assign start_req = core.ctrl_write && core.ctrl_wdata[`CTRL_WR_BIT];
   assign start_ok  = start_req && (key_state == key_done) && (state == st_idle)
                      && core.ctrl_wdata[`CTRL_WREN_BIT] && op_valid;
   assign done      = ((state == st_settle) || (state == st_erase)) && (wait_cnt == 8'h01);
   assign tw_slot   = core.tw_addr[`SLOT_W:1];

   // ----------------------------------------------------------------
   // Stall and status
   // ----------------------------------------------------------------
   assign busy       = (state != st_idle);
   assign core.stall = busy;
   assign core.tw_ack = tw_phase;
   assign core.ctrl_rdata = {wr, wren, err, 9'h000, op};

   // ----------------------------------------------------------------
   // Table writes into the holding buffer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         tw_phase <= 1'b0;
      end
      else if (core.tw_valid && !tw_phase && !busy)
      begin
         tw_phase <= 1'b1;
      end
      else
      begin
         tw_phase <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (tw_phase)
      begin
         if (core.tw_high)
         begin
            buffer[tw_slot][23:16] <= core.tw_data[7:0];
         end
         else
         begin
            buffer[tw_slot][15:0] <= core.tw_data;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         target <= 24'h000000;
      end
      else if (tw_phase)
      begin
         target <= core.tw_addr;
      end
   end

   // ----------------------------------------------------------------
   // Unlock key sequence
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         key_state <= key_none;
      end
      else if (core.key_write)
      begin
         if (core.key_data == `KEY_FIRST)
         begin
            key_state <= key_first;
         end
         else if ((key_state == key_first) && (core.key_data == `KEY_SECOND))
         begin
            key_state <= key_done;
         end
         else
         begin
            key_state <= key_none;
         end
      end
      else if (core.ctrl_write || core.tw_valid)
      begin
         key_state <= key_none;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         wr   <= 1'b0;
         wren <= 1'b0;
         err  <= 1'b0;
         op   <= 4'h0;
      end
      else
      begin
         if (done)
         begin
            wr <= 1'b0;
         end
         if (core.ctrl_write && (state == st_idle))
         begin
            wren <= core.ctrl_wdata[`CTRL_WREN_BIT];
            op   <= start_op;
            err  <= core.ctrl_wdata[`CTRL_ERR_BIT];
            if (start_ok)
            begin
               wr <= 1'b1;
            end
            else if (start_req)
            begin
               err <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state    <= st_idle;
         slot     <= 6'h00;
         wait_cnt <= 8'h00;
      end
      else
      begin
         unique case (state)
            st_idle:
            begin
               if (start_ok)
               begin
                  if (start_op == `OP_ERASE)
                  begin
                     state    <= st_erase;
                     wait_cnt <= ERASE_CYC;
                  end
                  else if (start_op == `OP_ROW)
                  begin
                     state <= st_load;
                     slot  <= 6'h00;
                  end
                  else
                  begin
                     state <= st_load;
                     slot  <= target[`SLOT_W:1];
                  end
               end
            end
            st_load:
            begin
               if ((op == `OP_WORD) || (slot == `LAST_SLOT))
               begin
                  state    <= st_settle;
                  wait_cnt <= PROG_CYC;
               end
               else
               begin
                  slot <= slot + 6'h01;
               end
            end
            st_settle, st_erase:
            begin
               if (wait_cnt == 8'h01)
               begin
                  state <= st_idle;
               end
               else
               begin
                  wait_cnt <= wait_cnt - 8'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flash array drive
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         array_we    <= 1'b0;
         array_addr  <= 24'h000000;
         array_data  <= 24'h000000;
         array_erase <= 1'b0;
      end
      else
      begin
         array_we    <= (state == st_load);
         array_erase <= start_ok && (start_op == `OP_ERASE);
         if (state == st_load)
         begin
            array_data <= buffer[slot];
            array_addr <= (target & `ROW_ADDR_MASK) | {17'h00000, slot, 1'b0};
         end
         else if (start_ok && (start_op == `OP_ERASE))
         begin
            array_addr <= target & `PAGE_ADDR_MASK;
         end
      end
   end

endmodule

/* verilog/flash_sequencer_host.sv */
// Processor core end: loads the holding buffer, unlocks and starts operations.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_sequencer_host
   import flash_seq_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         reset,
   flash_seq_if.core         core,
   input  wire logic         cmd_valid,
   input  wire cmd_kind_t    cmd_kind,
   input  wire logic [23:0]  cmd_addr,
   input  wire logic [15:0]  cmd_data,
   output logic              cmd_ready,
   output logic              op_done,
   output logic              op_error
);

   host_state_t  state;
   logic [23:0]  addr_q;
   logic [15:0]  data_q;
   logic         high_q;

   // ----------------------------------------------------------------
   // Request handshake
   // ----------------------------------------------------------------
   assign cmd_ready       = (state == h_idle) && !core.stall;
   assign core.tw_valid   = (state == h_tw);
   assign core.tw_high    = high_q;
   assign core.tw_addr    = addr_q;
   assign core.tw_data    = data_q;
   assign core.key_write  = (state == h_key1) || (state == h_key2);
   assign core.key_data   = (state == h_key2) ? `KEY_SECOND : `KEY_FIRST;
   assign core.ctrl_write = (state == h_ctrl);
   assign core.ctrl_wdata = {1'b1, 1'b1, 10'h000, data_q[3:0]};

   // ----------------------------------------------------------------
   // Command latch
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         addr_q <= 24'h000000;
         data_q <= 16'h0000;
         high_q <= 1'b0;
      end
      else if (cmd_valid && cmd_ready)
      begin
         addr_q <= cmd_addr;
         data_q <= cmd_data;
         high_q <= (cmd_kind == cmd_load_high);
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state    <= h_idle;
         op_done  <= 1'b0;
         op_error <= 1'b0;
      end
      else
      begin
         op_done <= 1'b0;
         unique case (state)
            h_idle:
            begin
               if (cmd_valid && cmd_ready)
               begin
                  state <= (cmd_kind == cmd_start) ? h_key1 : h_tw;
               end
            end
            h_tw:
            begin
               if (core.tw_ack)
               begin
                  state <= h_idle;
               end
            end
            h_key1:
            begin
               state <= h_key2;
            end
            h_key2:
            begin
               state <= h_ctrl;
            end
            h_ctrl:
            begin
               state <= h_wait;
            end
            h_wait:
            begin
               if (!core.stall)
               begin
                  state    <= h_idle;
                  op_done  <= 1'b1;
                  op_error <= core.ctrl_rdata[`CTRL_ERR_BIT];
               end
            end
            default:
            begin
               state <= h_idle;
            end
         endcase
      end
   end

endmodule

/* dv/flash_seq_assertions.sv */
// Assertions on the link between the core end and the flash sequencer.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_seq_assertions
(
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        tw_valid,
   input wire logic        tw_ack,
   input wire logic        key_write,
   input wire logic [7:0]  key_data,
   input wire logic        ctrl_write,
   input wire logic [15:0] ctrl_wdata,
   input wire logic [15:0] ctrl_rdata,
   input wire logic        stall
);
   logic [7:0] stall_cnt;
   logic [3:0] run_op;

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // Stall length and operation tracking
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         stall_cnt <= 8'h00;
      end
      else
      begin
         stall_cnt <= stall ? stall_cnt + 8'h01 : 8'h00;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         run_op <= 4'h0;
      end
      else if (ctrl_write && !stall)
      begin
         run_op <= ctrl_wdata[3:0];
      end
   end

   sequence unlock_s;
      key_write && key_data == `KEY_FIRST ##1 key_write && key_data == `KEY_SECOND ##1
      ctrl_write && !stall && ctrl_wdata[15:14] == 2'h3 && ctrl_wdata[3:0] inside {`OP_WORD, `OP_ROW, `OP_ERASE};
   endsequence

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   ack_single_a: assert property (tw_ack |=> !tw_ack)
      else $error("table write ack longer than one cycle");
   ack_timing_a: assert property (tw_valid && !tw_ack && !stall |=> tw_ack)
      else $error("table write ack missing one cycle after request");
   ack_cause_a: assert property (tw_ack |-> $past(tw_valid) && !$past(stall))
      else $error("table write ack without request");
   unlock_start_a: assert property (unlock_s |=> stall && ctrl_rdata[`CTRL_WR_BIT])
      else $error("unlocked start did not launch");
   wr_follows_stall_a: assert property (ctrl_rdata[`CTRL_WR_BIT] == stall)
      else $error("start bit and stall disagree");
   stall_length_a: assert property ($fell(stall) |-> (run_op == `OP_ERASE && stall_cnt == 8'h20) ||
      (run_op == `OP_ROW && stall_cnt inside {8'h50, 8'h51}) ||
      (run_op == `OP_WORD && stall_cnt inside {8'h11, 8'h12}))
      else $error("operation stall length wrong");
   stalled_no_ack_a: assert property (stall && $past(stall) |-> !tw_ack)
      else $error("table write taken while stalled");
   bad_op_a: assert property (ctrl_write && !stall && !(ctrl_wdata[3:0] inside {`OP_WORD, `OP_ROW, `OP_ERASE})
      |=> !stall && ctrl_rdata[`CTRL_ERR_BIT])
      else $error("bad start not refused");

   row_done_c: cover property ($fell(stall) && run_op == `OP_ROW);
   erase_done_c: cover property ($fell(stall) && run_op == `OP_ERASE);
   ack_seen_c: cover property (tw_ack);
endmodule

/* dv/tb_top.sv */
// Testbench for the core end and the flash sequencer working together.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module tb_top
   import flash_seq_pkg::*;
;
   logic        sys_clk;
   logic        reset;
   logic        cmd_valid;
   cmd_kind_t   cmd_kind;
   logic [23:0] cmd_addr;
   logic [15:0] cmd_data;
   logic        cmd_ready;
   logic        op_done;
   logic        op_error;
   logic        array_we;
   logic [23:0] array_addr;
   logic [23:0] array_data;
   logic        array_erase;
   logic        busy;
   logic [23:0] erase_addr;
   logic [23:0] wr_addr_q[$];
   logic [23:0] wr_data_q[$];
   int          err_count;
   int          samples_checked;
   int          cycles;
   int          done_count;
   int          erase_count;
   int          b_ack_count;
   int          busy_count;
   int          k;

   flash_seq_if aif();
   flash_seq_if bif();

   flash_sequencer_host flash_sequencer_host_i(.sys_clk(sys_clk), .reset(reset), .core(aif),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .op_done(op_done), .op_error(op_error));
   flash_sequencer_device flash_sequencer_device_i(.sys_clk(sys_clk), .reset(reset), .core(aif),
      .array_we(array_we), .array_addr(array_addr), .array_data(array_data),
      .array_erase(array_erase), .busy(busy));
   flash_sequencer_device flash_sequencer_device_i2(.sys_clk(sys_clk), .reset(reset), .core(bif),
      .array_we(), .array_addr(), .array_data(), .array_erase(), .busy());
   flash_seq_assertions flash_seq_assertions_i(.sys_clk(sys_clk), .reset(reset),
      .tw_valid(aif.tw_valid), .tw_ack(aif.tw_ack), .key_write(aif.key_write),
      .key_data(aif.key_data), .ctrl_write(aif.ctrl_write), .ctrl_wdata(aif.ctrl_wdata),
      .ctrl_rdata(aif.ctrl_rdata), .stall(aif.stall));

   // ----------------------------------------------------------------
   // Clock, monitors and timeout
   // ----------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles++;
      if (array_we === 1'b1)
      begin
         wr_addr_q.push_back(array_addr);
         wr_data_q.push_back(array_data);
      end
      if (array_erase === 1'b1)
      begin
         erase_count++;
         erase_addr = array_addr;
      end
      done_count += int'(op_done === 1'b1);
      b_ack_count += int'(bif.tw_ack === 1'b1);
      busy_count += int'(busy === 1'b1);
      if (cycles == 4000)
      begin
         err_count++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_num(input int got, input int exp);
      samples_checked++;
      if (got != exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask

   task automatic send(input cmd_kind_t kind, input logic [23:0] addr, input logic [15:0] data);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_kind = kind;
      cmd_addr = addr;
      cmd_data = data;
      wait_ready();
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      wait_ready();
   endtask

   function automatic logic [23:0] word_of(input int n);
      return {8'(n) ^ 8'hC3, 16'(n * 515) ^ 16'h6A5C};
   endfunction

   task automatic load_word(input logic [23:0] addr, input logic [23:0] w);
      send(cmd_load_low, addr, w[15:0]);
      send(cmd_load_high, addr, {8'h00, w[23:16]});
   endtask

   task automatic run_op(input logic [3:0] op, input int writes, input logic err, input int busy_cycles);
      int d;
      d = done_count;
      wr_addr_q.delete();
      wr_data_q.delete();
      erase_count = 0;
      busy_count = 0;
      send(cmd_start, 24'h000000, {12'h000, op});
      repeat (2) @(negedge sys_clk);
      check_num(done_count, d + 1);
      check_num(wr_addr_q.size(), writes);
      check_val(24'(op_error), 24'(err));
      check_num(busy_count, busy_cycles);
   endtask

   task automatic b_step(input logic kw, input logic [7:0] kd, input logic cw, input logic [15:0] cd);
      bif.key_write = kw;
      bif.key_data = kd;
      bif.ctrl_write = cw;
      bif.ctrl_wdata = cd;
      @(negedge sys_clk);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = cmd_load_low;
      cmd_addr = 24'h000000;
      cmd_data = 16'h0000;
      bif.tw_valid = 1'b0;
      bif.tw_high = 1'b0;
      bif.tw_addr = 24'h000000;
      bif.tw_data = 16'h0000;
      bif.key_write = 1'b0;
      bif.key_data = 8'h00;
      bif.ctrl_write = 1'b0;
      bif.ctrl_wdata = 16'h0000;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      for (k = 0; k < 64; k++)
      begin
         load_word(24'h000180 + 24'(2 * k), word_of(k));
      end
      run_op(`OP_ROW, 64, 1'b0, `ROW_INSTR + `PROG_SETTLE_NS / `CLK_PERIOD_NS);
      for (k = 0; k < 64; k++)
      begin
         check_val(wr_addr_q[k], 24'h000180 + 24'(2 * k));
         check_val(wr_data_q[k], word_of(k));
      end
      load_word(24'h0001C6, 24'h3C96A5);
      run_op(4'h0, 0, 1'b1, 0);
      run_op(`OP_WORD, 1, 1'b0, 1 + `PROG_SETTLE_NS / `CLK_PERIOD_NS);
      check_val(wr_addr_q[0], 24'h0001C6);
      check_val(wr_data_q[0], 24'h3C96A5);
      send(cmd_load_low, 24'h000E46, 16'h0000);
      run_op(`OP_ERASE, 0, 1'b0, `ERASE_TIME_NS / `CLK_PERIOD_NS);
      check_num(erase_count, 1);
      check_val(erase_addr, 24'h000C00);
      b_step(1'b0, 8'h00, 1'b1, 16'hC002);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'({bif.stall, bif.ctrl_rdata[15], bif.ctrl_rdata[13]}), 24'h000001);
      b_step(1'b0, 8'h00, 1'b1, 16'h0000);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'(bif.ctrl_rdata[13]), 24'h000000);
      b_step(1'b1, 8'h55, 1'b0, 16'h0000);
      b_step(1'b1, 8'h12, 1'b0, 16'h0000);
      b_step(1'b1, 8'hAA, 1'b0, 16'h0000);
      b_step(1'b0, 8'h00, 1'b1, 16'hC002);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'({bif.stall, bif.ctrl_rdata[13]}), 24'h000001);
      b_step(1'b1, 8'h55, 1'b0, 16'h0000);
      b_step(1'b1, 8'hAA, 1'b0, 16'h0000);
      b_step(1'b0, 8'h00, 1'b1, 16'hC003);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'({bif.stall, bif.ctrl_rdata[15]}), 24'h000003);
      bif.tw_valid = 1'b1;
      repeat (4) @(negedge sys_clk);
      bif.tw_valid = 1'b0;
      check_num(b_ack_count, 0);
      k = 0;
      while (bif.stall === 1'b1 && k < 100)
      begin
         @(negedge sys_clk);
         k++;
      end
      check_val(24'({bif.stall, bif.ctrl_rdata[15]}), 24'h000000);
      b_step(1'b0, 8'h00, 1'b1, 16'hC003);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'(bif.stall), 24'h000000);
      b_step(1'b0, 8'h00, 1'b1, 16'h0000);
      b_step(1'b1, 8'h55, 1'b0, 16'h0000);
      b_step(1'b1, 8'hAA, 1'b0, 16'h0000);
      b_step(1'b0, 8'h00, 1'b1, 16'h8003);
      b_step(1'b0, 8'h00, 1'b0, 16'h0000);
      check_val(24'({bif.stall, bif.ctrl_rdata[15], bif.ctrl_rdata[13]}), 24'h000001);
      stop_test();
   end
endmodule
